// *** hdl/sptpr_timer.sv ***
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`include "sptpr_regs.svh"
// What this block does
// - Each half holds an 8-bit prescale (0 to 255) written to half A, half B or both at once.
// - The prescaler divides only in the split 16-bit configuration and is bypassed otherwise.
// - In capture mode the prescale match joins the 16-bit match into a 24-bit compare.
// - In rtc configuration clearing the rtc enable stops the counter advancing.
// - Setting the rtc enable with half A enabled starts counting only in rtc configuration, elsewhere no effect.
// - Software may read either half's present count at any time without disturbing it.
// - Writing a load value while running loads it into the counter at once.
// - The match sets the capture-count event point and the pwm duty cycle.
module sptpr_timer
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// capture edge inputs, asynchronous
	input  wire logic        cap_a_i,
	input  wire logic        cap_b_i,
	// events and outputs
	output logic             timeout_a_o,
	output logic             timeout_b_o,
	output logic             match_a_o,
	output logic             match_b_o,
	output logic             rtc_match_o,
	output logic             pwm_a_o,
	output logic             pwm_b_o
);

	sptpr_pkg::sptpr_cfg_type      cfg;
	sptpr_pkg::sptpr_half_cfg_type half [2];
	logic                          rtc_en;
	logic [31:0]                   rtc_match;
	logic [15:0]                   cnt [2];
	logic [7:0]                    pcnt [2];
	logic [31:0]                   cnt32;
	logic [2:0]                    cap_sync [2];
	logic [1:0]                    cap_edge;
	logic [1:0]                    cap_lvl;
	logic [1:0]                    tick;
	logic [1:0]                    hit16;
	logic [1:0]                    load_wr;
	logic                          wr;
	logic                          rd;
	logic                          mapped;
	logic [31:0]                   next_rdata;

	assign wr = psel_i & penable_i & pwrite_i;
	assign rd = psel_i & penable_i & ~pwrite_i;
	assign pready_o = 1'b1;
	assign load_wr[0] = wr & (paddr_i == `SPTPR_LOAD_A_OFF);
	assign load_wr[1] = wr & (paddr_i == `SPTPR_LOAD_B_OFF);

	// config and control registers
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			cfg <= sptpr_pkg::SPTPR_SPLIT;
			rtc_en <= 1'b0;
			rtc_match <= 32'h0000_0000;
		end
		else if (wr && paddr_i == `SPTPR_CFG_OFF)
			cfg <= sptpr_pkg::sptpr_cfg_type'(pwdata_i[`SPTPR_CFG_MODE_LSB +: 2]);
		else if (wr && paddr_i == `SPTPR_CTL_OFF)
			rtc_en <= pwdata_i[`SPTPR_CTL_RTC_EN];
		else if (wr && paddr_i == `SPTPR_MATCH_A_OFF && cfg != sptpr_pkg::SPTPR_SPLIT)
			rtc_match <= pwdata_i;
	end

	// per-half settings; the both offsets write both halves in one access
	for (genvar h = 0; h < 2; h++)
	begin : g_half
		always_ff @(posedge clk_i or posedge sys_rst_i)
		begin
			if (sys_rst_i)
			begin
				half[h].load <= `SPTPR_LOAD_RST;
				half[h].match <= `SPTPR_MATCH_RST;
				half[h].pre <= `SPTPR_PRE_RST;
				half[h].pmatch <= `SPTPR_PRE_RST;
				half[h].mode <= sptpr_pkg::SPTPR_ONE_SHOT;
				half[h].en <= 1'b0;
			end
			else if (wr)
			begin
				if (paddr_i == `SPTPR_CFG_OFF)
					half[h].mode <= sptpr_pkg::sptpr_half_mode_type'(
						pwdata_i[(h == 0 ? `SPTPR_CFG_HALF_A : `SPTPR_CFG_HALF_B) +: 2]);
				if (paddr_i == `SPTPR_CTL_OFF)
					half[h].en <= pwdata_i[h];
				if (load_wr[h])
					half[h].load <= pwdata_i[15:0];
				if (paddr_i == (h == 0 ? `SPTPR_MATCH_A_OFF : `SPTPR_MATCH_B_OFF))
					half[h].match <= pwdata_i[15:0];
				if (paddr_i == (h == 0 ? `SPTPR_PRE_A_OFF : `SPTPR_PRE_B_OFF)
					|| paddr_i == `SPTPR_PRE_BOTH_OFF)
					half[h].pre <= pwdata_i[7:0];
				if (paddr_i == (h == 0 ? `SPTPR_PMATCH_A_OFF : `SPTPR_PMATCH_B_OFF)
					|| paddr_i == `SPTPR_PMATCH_BOTH_OFF)
					half[h].pmatch <= pwdata_i[7:0];
			end
		end

		// capture pin: a rise counts when second and third stage agree high
		always_ff @(posedge clk_i or posedge sys_rst_i)
		begin
			if (sys_rst_i)
				cap_sync[h] <= 3'b000;
			else
				cap_sync[h] <= {cap_sync[h][1:0], (h == 0) ? cap_a_i : cap_b_i};
		end
		// agreed level resets to the idle low pin, so no false edge after reset
		always_ff @(posedge clk_i or posedge sys_rst_i)
		begin
			if (sys_rst_i)
				cap_lvl[h] <= 1'b0;
			else if (cap_sync[h][1] == cap_sync[h][2])
				cap_lvl[h] <= cap_sync[h][2];
		end
		assign cap_edge[h] = cap_sync[h][1] & cap_sync[h][2] & ~cap_lvl[h];

		// prescaler divides by pre+1 only in split mode
		always_ff @(posedge clk_i or posedge sys_rst_i)
		begin
			if (sys_rst_i)
				pcnt[h] <= 8'h00;
			else if (cfg != sptpr_pkg::SPTPR_SPLIT || load_wr[h])
				pcnt[h] <= 8'h00;
			// wrap at or above the limit: lowering the prescale must not stall the divider
			else if (half[h].en && half[h].mode != sptpr_pkg::SPTPR_CAPTURE)
				pcnt[h] <= (pcnt[h] >= half[h].pre) ? 8'h00 : pcnt[h] + 8'h01;
		end

		always_comb
		begin
			tick[h] = 1'b0;
			if (half[h].en)
			begin
				if (half[h].mode == sptpr_pkg::SPTPR_CAPTURE)
					tick[h] = cap_edge[h];
				else
					tick[h] = (pcnt[h] >= half[h].pre);
			end
		end

		// 24-bit compare: prescale match above the 16-bit match
		assign hit16[h] = ({pcnt[h], cnt[h]} == {half[h].pmatch, half[h].match});

		// down counter with immediate reload on load write
		always_ff @(posedge clk_i or posedge sys_rst_i)
		begin
			if (sys_rst_i)
				cnt[h] <= `SPTPR_LOAD_RST;
			else if (load_wr[h])
				cnt[h] <= pwdata_i[15:0];
			else if (cfg == sptpr_pkg::SPTPR_SPLIT && tick[h])
			begin
				if (cnt[h] != 16'h0000)
					cnt[h] <= cnt[h] - 16'h0001;
				else if (half[h].mode != sptpr_pkg::SPTPR_ONE_SHOT)
					cnt[h] <= half[h].load;
			end
		end

	end

	// event pulses, registered; one process so each output has a single driver
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			timeout_a_o <= 1'b0;
			timeout_b_o <= 1'b0;
			match_a_o <= 1'b0;
			match_b_o <= 1'b0;
			pwm_a_o <= 1'b0;
			pwm_b_o <= 1'b0;
		end
		else
		begin
			timeout_a_o <= cfg == sptpr_pkg::SPTPR_SPLIT && tick[0] && cnt[0] == 16'h0000
				&& half[0].mode != sptpr_pkg::SPTPR_CAPTURE;
			match_a_o <= cfg == sptpr_pkg::SPTPR_SPLIT && tick[0] && hit16[0]
				&& half[0].mode == sptpr_pkg::SPTPR_CAPTURE;
			pwm_a_o <= cfg == sptpr_pkg::SPTPR_SPLIT && half[0].mode == sptpr_pkg::SPTPR_PWM
				&& cnt[0] <= half[0].match;
			timeout_b_o <= cfg == sptpr_pkg::SPTPR_SPLIT && tick[1] && cnt[1] == 16'h0000
				&& half[1].mode != sptpr_pkg::SPTPR_CAPTURE;
			match_b_o <= cfg == sptpr_pkg::SPTPR_SPLIT && tick[1] && hit16[1]
				&& half[1].mode == sptpr_pkg::SPTPR_CAPTURE;
			pwm_b_o <= cfg == sptpr_pkg::SPTPR_SPLIT && half[1].mode == sptpr_pkg::SPTPR_PWM
				&& cnt[1] <= half[1].match;
		end
	end

	// joined counter: periodic down count, or rtc up count gated by rtc enable
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			cnt32 <= 32'hFFFF_FFFF;
		else if (cfg == sptpr_pkg::SPTPR_JOINED && wr && paddr_i == `SPTPR_LOAD_A_OFF)
			cnt32 <= pwdata_i;
		else if (cfg == sptpr_pkg::SPTPR_RTC && wr && paddr_i == `SPTPR_LOAD_A_OFF)
			cnt32 <= pwdata_i;
		else if (cfg == sptpr_pkg::SPTPR_RTC)
		begin
			if (rtc_en && half[0].en)
				cnt32 <= cnt32 + 32'h0000_0001;
		end
		else if (cfg == sptpr_pkg::SPTPR_JOINED && half[0].en)
			cnt32 <= (cnt32 == 32'h0000_0000) ? {half[1].load, half[0].load}
				: cnt32 - 32'h0000_0001;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			rtc_match_o <= 1'b0;
		else
			rtc_match_o <= cfg == sptpr_pkg::SPTPR_RTC && rtc_en && cnt32 == rtc_match;
	end

	// read mux; value reads are side-effect free
	always_comb
	begin
		mapped = 1'b1;
		next_rdata = 32'h0000_0000;
		case (paddr_i)
			`SPTPR_CFG_OFF:      next_rdata = {22'h0, half[1].mode, 2'h0, half[0].mode,
				2'h0, cfg};
			`SPTPR_CTL_OFF:      next_rdata = {29'h0, rtc_en, half[1].en, half[0].en};
			`SPTPR_LOAD_A_OFF:   next_rdata = {16'h0, half[0].load};
			`SPTPR_LOAD_B_OFF:   next_rdata = {16'h0, half[1].load};
			`SPTPR_MATCH_A_OFF:  next_rdata = {16'h0, half[0].match};
			`SPTPR_MATCH_B_OFF:  next_rdata = {16'h0, half[1].match};
			`SPTPR_PRE_A_OFF:    next_rdata = {24'h0, half[0].pre};
			`SPTPR_PRE_B_OFF:    next_rdata = {24'h0, half[1].pre};
			`SPTPR_PMATCH_A_OFF: next_rdata = {24'h0, half[0].pmatch};
			`SPTPR_PMATCH_B_OFF: next_rdata = {24'h0, half[1].pmatch};
			`SPTPR_VALUE_A_OFF:  next_rdata = (cfg == sptpr_pkg::SPTPR_SPLIT)
				? {16'h0, cnt[0]} : cnt32;
			`SPTPR_VALUE_B_OFF:  next_rdata = {16'h0, cnt[1]};
			`SPTPR_PRE_BOTH_OFF, `SPTPR_PMATCH_BOTH_OFF: next_rdata = 32'h0000_0000;
			default:             mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			prdata_o <= 32'h0000_0000;
		else if (psel_i && !penable_i && !pwrite_i)
			prdata_o <= next_rdata;
	end

	// unmapped addresses answer with an error
	assign pslverr_o = psel_i & penable_i & ~mapped;

endmodule // sptpr_timer

// *** include/sptpr_regs.svh ***
`ifndef SPTPR_REGS_SVH
`define SPTPR_REGS_SVH

// register byte offsets
`define SPTPR_CFG_OFF      12'h000
`define SPTPR_CTL_OFF      12'h004
`define SPTPR_LOAD_A_OFF   12'h008
`define SPTPR_LOAD_B_OFF   12'h00C
`define SPTPR_MATCH_A_OFF  12'h010
`define SPTPR_MATCH_B_OFF  12'h014
`define SPTPR_PRE_A_OFF    12'h018
`define SPTPR_PRE_B_OFF    12'h01C
`define SPTPR_PMATCH_A_OFF 12'h020
`define SPTPR_PMATCH_B_OFF 12'h024
`define SPTPR_VALUE_A_OFF  12'h028
`define SPTPR_VALUE_B_OFF  12'h02C
`define SPTPR_PRE_BOTH_OFF 12'h030
`define SPTPR_PMATCH_BOTH_OFF 12'h034

// field positions in the control register
`define SPTPR_CTL_EN_A     0
`define SPTPR_CTL_EN_B     1
`define SPTPR_CTL_RTC_EN   2

// field positions in the config register
`define SPTPR_CFG_MODE_LSB 0
`define SPTPR_CFG_HALF_A   4
`define SPTPR_CFG_HALF_B   8

// reset values and the prescale maximum
`define SPTPR_PRE_RST      8'h00
`define SPTPR_LOAD_RST     16'hFFFF
`define SPTPR_MATCH_RST    16'h0000
`define SPTPR_PRE_MAX      8'hFF

`endif

// *** include/sptpr_pkg.sv ***
package sptpr_pkg;

	// module-wide configuration
	typedef enum logic [1:0]
	{
		SPTPR_SPLIT  = 2'b00,
		SPTPR_JOINED = 2'b01,
		SPTPR_RTC    = 2'b10
	} sptpr_cfg_type;

	// per-half 16-bit mode
	typedef enum logic [1:0]
	{
		SPTPR_ONE_SHOT = 2'b00,
		SPTPR_PERIODIC = 2'b01,
		SPTPR_CAPTURE  = 2'b10,
		SPTPR_PWM      = 2'b11
	} sptpr_half_mode_type;

	// settings of one half
	typedef struct packed
	{
		logic [15:0] load;
		logic [15:0] match;
		logic [7:0]  pre;
		logic [7:0]  pmatch;
		sptpr_half_mode_type mode;
		logic        en;
	} sptpr_half_cfg_type;

endpackage

// *** tb/sptpr_checker.sv ***
`timescale 1ns/1ps
module sptpr_checker
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// apb
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] prdata_o,
	input  wire logic        pready_o,
	input  wire logic        pslverr_o,
	// events
	input  wire logic        timeout_a_o,
	input  wire logic        timeout_b_o,
	input  wire logic        match_a_o,
	input  wire logic        match_b_o,
	input  wire logic        rtc_match_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_rdy; psel_i && penable_i |-> pready_o; endproperty
	a_rdy: assert property (p_rdy) else $error("pready low in access");
	property p_err_hi; psel_i && penable_i && paddr_i > 12'h034 |-> pslverr_o; endproperty
	a_err_hi: assert property (p_err_hi) else $error("no error on unmapped");
	property p_err_lo;
		pslverr_o |-> psel_i && penable_i && (paddr_i > 12'h034 || paddr_i[1:0] != 2'h0);
	endproperty
	a_err_lo: assert property (p_err_lo) else $error("stray slave error");
	property p_hold; !(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_both;
		psel_i && !penable_i && !pwrite_i && (paddr_i == 12'h030 || paddr_i == 12'h034)
		|=> prdata_o == 32'h0;
	endproperty
	a_both: assert property (p_both) else $error("both offset not zero");
	property p_xa; !(timeout_a_o && match_a_o); endproperty
	a_xa: assert property (p_xa) else $error("half a timeout with match");
	property p_xb; !(timeout_b_o && match_b_o); endproperty
	a_xb: assert property (p_xb) else $error("half b timeout with match");
	property p_rtc; rtc_match_o |-> !(timeout_a_o || timeout_b_o); endproperty
	a_rtc: assert property (p_rtc) else $error("timeout in rtc config");
endmodule // sptpr_checker

bind sptpr_timer sptpr_checker i_sptpr_checker (.clk_i, .sys_rst_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .timeout_a_o, .timeout_b_o,
	.match_a_o, .match_b_o, .rtc_match_o);

// *** tb/sptpr_timer_tb.sv ***
`timescale 1ns/1ps
`include "sptpr_regs.svh"
module sptpr_timer_tb;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        pwm_a_o;
	logic        pwm_b_o;
	logic        cap_a_i = 1'b0;
	logic        cap_b_i = 1'b0;
	logic        timeout_a_o;
	logic        timeout_b_o;
	logic        match_a_o;
	logic        match_b_o;
	logic        rtc_match_o;
	int          n_to_a = 0;
	int          n_to_b = 0;
	int          n_ma = 0;
	int          n_mb = 0;
	logic [31:0] v0;
	logic [31:0] v1;
	logic        er;
	int          miscompares = 0;
	int          n_compared = 0;
	int          cyc = 0;
	always #5 clk_i = ~clk_i;
	sptpr_timer i_sptpr_timer (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cap_a_i, .cap_b_i,
		.timeout_a_o, .timeout_b_o, .match_a_o, .match_b_o, .rtc_match_o,
		.pwm_a_o, .pwm_b_o);
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		@(posedge clk_i);
		// the wait ends once pready_o is high, or at the bench timeout
		while (pready_o !== 1'b1)
		begin
			@(posedge clk_i);
		end
		q = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, v0);
		chk("read", e, v0);
	endtask
	// read setups exactly 40 cycles apart
	task automatic gap(input string nm, input logic [31:0] e);
		xfer(1'b0, `SPTPR_VALUE_A_OFF, 32'h0, v0);
		repeat (37) @(posedge clk_i);
		xfer(1'b0, `SPTPR_VALUE_A_OFF, 32'h0, v1);
		chk(nm, e, v0 - v1);
	endtask
	// cleared off the counting edge to avoid a race with the counters
	task automatic zero_counts;
		@(negedge clk_i);
		n_to_a = 0;
		n_to_b = 0;
		n_ma = 0;
		n_mb = 0;
	endtask
	task automatic cap_pulses;
		repeat (2)
		begin
			@(posedge clk_i);
			cap_a_i <= 1'b1;
			repeat (4) @(posedge clk_i);
			cap_a_i <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
	endtask
	task automatic complete_run;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		if (timeout_a_o === 1'b1)
			n_to_a++;
		if (timeout_b_o === 1'b1)
			n_to_b++;
		if (match_a_o === 1'b1)
			n_ma++;
		if (match_b_o === 1'b1)
			n_mb++;
		cyc++;
		if (cyc == 5000)
		begin
			miscompares++;
			complete_run();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		wr(`SPTPR_PRE_A_OFF, 32'hFF);
		wr(`SPTPR_PRE_B_OFF, 32'h01);
		rdchk(`SPTPR_PRE_A_OFF, 32'hFF);
		rdchk(`SPTPR_PRE_B_OFF, 32'h01);
		wr(`SPTPR_PRE_BOTH_OFF, 32'h5A);
		wr(`SPTPR_PMATCH_BOTH_OFF, 32'hFF);
		rdchk(`SPTPR_PRE_A_OFF, 32'h5A);
		rdchk(`SPTPR_PRE_B_OFF, 32'h5A);
		rdchk(`SPTPR_PMATCH_B_OFF, 32'hFF);
		rdchk(`SPTPR_PRE_BOTH_OFF, 32'h0);
		rdchk(12'h040, 32'h0);
		chk("pslverr", 32'h1, {31'h0, er});
		$display("test registers done");
		wr(`SPTPR_CFG_OFF, 32'h10);
		wr(`SPTPR_PRE_A_OFF, 32'h3);
		wr(`SPTPR_CTL_OFF, 32'h1);
		wr(`SPTPR_LOAD_A_OFF, 32'h8000);
		gap("div4", 32'h0A);
		wr(`SPTPR_PRE_A_OFF, 32'h0);
		gap("div1", 32'h28);
		wr(`SPTPR_PRE_A_OFF, 32'h3);
		wr(`SPTPR_LOAD_A_OFF, 32'h1234);
		rdchk(`SPTPR_VALUE_A_OFF, 32'h1234);
		$display("test prescale done");
		wr(`SPTPR_CFG_OFF, 32'h330);
		wr(`SPTPR_LOAD_B_OFF, 32'h0);
		wr(`SPTPR_MATCH_A_OFF, 32'h1F4);
		wr(`SPTPR_LOAD_A_OFF, 32'h190);
		repeat (2) @(negedge clk_i);
		chk("pwm low count", 32'h1, {31'h0, pwm_a_o});
		chk("pwm b at zero", 32'h1, {31'h0, pwm_b_o});
		wr(`SPTPR_LOAD_A_OFF, 32'h3E8);
		repeat (2) @(negedge clk_i);
		chk("pwm high count", 32'h0, {31'h0, pwm_a_o});
		$display("test pwm done");
		wr(`SPTPR_CFG_OFF, 32'h110);
		wr(`SPTPR_PRE_A_OFF, 32'h0);
		wr(`SPTPR_PRE_B_OFF, 32'h1);
		wr(`SPTPR_LOAD_A_OFF, 32'h3);
		wr(`SPTPR_LOAD_B_OFF, 32'h4);
		wr(`SPTPR_CTL_OFF, 32'h3);
		repeat (20) @(posedge clk_i);
		zero_counts();
		repeat (40) @(negedge clk_i);
		chk("timeouts a", 32'h0A, n_to_a);
		chk("timeouts b", 32'h4, n_to_b);
		$display("test timeout done");
		wr(`SPTPR_PMATCH_A_OFF, 32'h0);
		wr(`SPTPR_MATCH_A_OFF, 32'h2);
		wr(`SPTPR_CFG_OFF, 32'h220);
		wr(`SPTPR_LOAD_A_OFF, 32'h3);
		zero_counts();
		cap_pulses();
		chk("capture match a", 32'h1, n_ma);
		chk("capture match b", 32'h0, n_mb);
		chk("capture timeout a", 32'h0, n_to_a);
		rdchk(`SPTPR_VALUE_A_OFF, 32'h1);
		$display("test capture done");
		wr(`SPTPR_PRE_A_OFF, 32'h3);
		wr(`SPTPR_CFG_OFF, 32'h01);
		wr(`SPTPR_CTL_OFF, 32'h7);
		wr(`SPTPR_LOAD_A_OFF, 32'h00012345);
		gap("joined", 32'h28);
		chk("joined upper", 32'h1, {16'h0, v1[31:16]});
		$display("test joined done");
		wr(`SPTPR_CFG_OFF, 32'h02);
		wr(`SPTPR_CTL_OFF, 32'h1);
		gap("rtc off", 32'h0);
		wr(`SPTPR_CTL_OFF, 32'h5);
		gap("rtc on", 32'hFFFFFFD8);
		wr(`SPTPR_CTL_OFF, 32'h1);
		gap("rtc stop", 32'h0);
		wr(`SPTPR_LOAD_A_OFF, 32'h100);
		wr(`SPTPR_MATCH_A_OFF, 32'h100);
		wr(`SPTPR_CTL_OFF, 32'h5);
		repeat (2) @(negedge clk_i);
		chk("rtc match", 32'h1, {31'h0, rtc_match_o});
		$display("test rtc done");
		complete_run();
	end
endmodule // sptpr_timer_tb
